/* hw/ptb_pkg.sv */
// What this block does
// - on region hit latch address, raise attention on a read; raise burst flag on burst
// - region, direction and lane status stay valid while attention is low
// - region index output carries the binary number of the hit region
// - direction output stays low for a bus read, add-on writes the port
// - lane status outputs all low for a full 32-bit access
// - write strobe edge captures add-on data; ready on same edge completes
// - ready high at an edge stretches the current data phase
// - on reads initiator wait states drop attention; it returns when they end
// - same behaviour whether write strobe stays low or drops with ready
// - burst flag drops when burst ends; later port writes are discarded
// - after final phase attention and burst drop; new access a clock later
// - read attention rises as soon as a hit frame is seen; write attention once a phase is buffered
// - first read phase needs ready by 15th edge after attention, else stop
// - on reads target ready goes out one clock after add-on ready
// - first two bus write phases are always accepted at once
// - later burst phases need ready within eight edges, else stop
// - after stop burst flag drops, other status held until attention ends
// - after stop on a read exactly one more write, its ready ends access
// - on writes attention stays until both buffers are read and readied
// - no new access until both write buffers are empty
// - 16-bit mode drives only low 16 address bits on address read
package ptb_pkg;
  localparam logic [6:0]  PT_DATA_OFS   = 7'h2c;
  localparam logic [31:0] PT_BASE       = 32'h8000_0000;
  localparam int          PT_WIN_LSB    = 12;
  localparam int          PT_REG_LSB    = 10;
  localparam logic [3:0]  FIRST_LIMIT   = 4'hf;
  localparam logic [3:0]  NEXT_LIMIT    = 4'h8;
  localparam logic [3:0]  LANES_IDLE_N  = 4'hf;
  localparam logic [1:0]  PHASES_FREE   = 2'h2;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  localparam logic [15:0] ZERO_HALF     = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_DONE
  } ptb_st_e;

  function automatic logic ptb_hit(input logic [31:0] a);
    ptb_hit = (a[31:PT_WIN_LSB] == PT_BASE[31:PT_WIN_LSB]);
  endfunction

  function automatic logic ptb_is_port(input logic       sel_n,
                                       input logic [6:2] adr);
    ptb_is_port = !sel_n && (adr == PT_DATA_OFS[6:2]);
  endfunction
endpackage

/* hw/ptb_wbuf.sv */
`timescale 1ns/1ps
module ptb_wbuf (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        push,
  input  wire logic [31:0] push_data,
  input  wire logic        pop,
  output logic [31:0]      head_data,
  output logic             empty,
  output logic             full
);
  import ptb_pkg::*;

  typedef struct packed {
    logic [1:0][31:0] mem;
    logic             wp;
    logic             rp;
    logic [1:0]       cnt;
    logic [31:0]      head;
  } ptb_wbuf_s;

  ptb_wbuf_s q_r;
  ptb_wbuf_s q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (push && (q_r.cnt != PHASES_FREE)) begin
      q_nxt.mem[q_r.wp] = push_data;
      q_nxt.wp = ~q_r.wp;
    end
    if (pop && (q_r.cnt != 2'h0)) begin
      q_nxt.rp = ~q_r.rp;
    end
    q_nxt.cnt = q_r.cnt
              + {1'b0, push && (q_r.cnt != PHASES_FREE)}
              - {1'b0, pop && (q_r.cnt != 2'h0)};
    // head is registered so the port read data come straight from a flop
    q_nxt.head = q_nxt.mem[q_nxt.rp];
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign head_data = q_r.head;
  assign empty     = (q_r.cnt == 2'h0);
  assign full      = (q_r.cnt == PHASES_FREE);
endmodule

/* hw/ptb_target_port.sv */
`timescale 1ns/1ps
module ptb_target_port (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        pci_frame_n,
  input  wire logic        pci_irdy_n,
  input  wire logic [31:0] pci_ad_in,
  input  wire logic [3:0]  pci_cbe_n,
  output logic [31:0]      pci_ad_out,
  output logic             pci_ad_oe,
  output logic             pci_trdy_n,
  output logic             pci_stop_n,
  input  wire logic        mode_16,
  input  wire logic        addon_sel_n,
  input  wire logic [6:2]  addon_adr,
  input  wire logic        addon_wr_n,
  input  wire logic        addon_rd_n,
  input  wire logic        addon_ready_n,
  input  wire logic        latched_addr_read_n,
  input  wire logic [31:0] addon_dq_in,
  output logic [31:0]      addon_dq_out,
  output logic             addon_dq_oe,
  output logic             passthru_attention_n,
  output logic             burst_flag_n,
  output logic [1:0]       region_index,
  output logic             xfer_direction,
  output logic [3:0]       pending_byte_lanes_n
);
  import ptb_pkg::*;

  typedef struct packed {
    ptb_st_e     st;
    logic        frame_m;
    logic        frame_s;
    logic        frame_d;
    logic        irdy_m;
    logic        irdy_s;
    logic [31:0] ad_m;
    logic [31:0] ad_s;
    logic [3:0]  cbe_m;
    logic [3:0]  cbe_s;
    logic [31:0] addr;
    logic [1:0]  region;
    logic        dir;
    logic [3:0]  lanes_n;
    logic        attn_n;
    logic        burst_n;
    logic        first;
    logic        retry;
    logic        bus_done;
    logic [1:0]  taken;
    logic [3:0]  wcnt;
    logic [2:0]  gap;
    logic [31:0] rdat;
    logic        trdy_n;
    logic        stop_n;
    logic [31:0] ad_out;
    logic        ad_oe;
    logic [31:0] dq_out;
    logic        dq_oe;
  } ptb_port_s;

  ptb_port_s q_r;
  ptb_port_s q_nxt;

  logic        buf_push;
  logic [31:0] buf_head;
  logic        buf_empty;
  logic        buf_full;
  logic        buf_pop;
  logic        port_wr;
  logic        port_rd;
  logic        ready;
  logic        new_frame;
  logic [3:0]  limit;

  assign port_wr   = ptb_is_port(addon_sel_n, addon_adr) && !addon_wr_n;
  assign port_rd   = ptb_is_port(addon_sel_n, addon_adr) && !addon_rd_n;
  // ready only counts while attention is low, so a stray ready is harmless
  assign ready     = !addon_ready_n && !q_r.attn_n;
  assign new_frame = q_r.frame_d && !q_r.frame_s;
  assign limit     = q_r.first ? FIRST_LIMIT : NEXT_LIMIT;
  assign buf_pop   = (q_r.st == ST_WRITE) && ready;
  // the initiator sees target ready three clocks late through the syncs,
  // so one phase stays on the bus that long and must not be taken twice
  assign buf_push  = (q_r.st == ST_WRITE) && !q_r.irdy_s && !q_r.bus_done
                   && !q_r.retry && !buf_full && (q_r.gap == 3'h0);

  ptb_wbuf u_wbuf (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .push      (buf_push),
    .push_data (q_r.ad_s),
    .pop       (buf_pop),
    .head_data (buf_head),
    .empty     (buf_empty),
    .full      (buf_full)
  );

  always_comb begin
    q_nxt = q_r;
    // pins pass two flops; the second stage is looked at, and for frame also a third
    q_nxt.frame_m = pci_frame_n;
    q_nxt.frame_s = q_r.frame_m;
    q_nxt.frame_d = q_r.frame_s;
    q_nxt.irdy_m  = pci_irdy_n;
    q_nxt.irdy_s  = q_r.irdy_m;
    q_nxt.ad_m    = pci_ad_in;
    q_nxt.ad_s    = q_r.ad_m;
    q_nxt.cbe_m   = pci_cbe_n;
    q_nxt.cbe_s   = q_r.cbe_m;
    q_nxt.trdy_n  = 1'b1;
    q_nxt.gap     = {q_r.gap[1:0], buf_push};
    if (q_r.frame_s && q_r.irdy_s) begin
      q_nxt.stop_n = 1'b1;
    end

    case (q_r.st)
      ST_IDLE: begin
        q_nxt.attn_n  = 1'b1;
        q_nxt.burst_n = 1'b1;
        q_nxt.ad_oe   = 1'b0;
        if (new_frame && ptb_hit(q_r.ad_s)) begin
          q_nxt.addr     = q_r.ad_s;
          q_nxt.region   = q_r.ad_s[PT_REG_LSB +: 2];
          q_nxt.dir      = q_r.cbe_s[0];
          q_nxt.attn_n   = q_r.cbe_s[0];
          q_nxt.lanes_n  = LANES_IDLE_N;
          q_nxt.first    = 1'b1;
          q_nxt.retry    = 1'b0;
          q_nxt.bus_done = 1'b0;
          q_nxt.taken    = 2'h0;
          q_nxt.wcnt     = 4'h0;
          q_nxt.st       = q_r.cbe_s[0] ? ST_WRITE : ST_READ;
        end
      end

      ST_READ: begin
        if (!q_r.irdy_s) begin
          q_nxt.lanes_n = q_r.cbe_s;
        end
        // a stop leaves attention up so the add-on can finish one word
        q_nxt.attn_n  = q_r.irdy_s && !q_r.retry;
        q_nxt.burst_n = q_r.retry || q_r.frame_s
                      || (q_r.first && q_r.irdy_s);
        if (port_wr && !q_r.attn_n) begin
          q_nxt.rdat = addon_dq_in;
        end
        if (ready) begin
          q_nxt.trdy_n = q_r.retry;
          q_nxt.ad_out = q_nxt.rdat;
          q_nxt.ad_oe  = 1'b1;
          q_nxt.first  = 1'b0;
          q_nxt.wcnt   = 4'h0;
          if (q_r.retry || q_r.frame_s) begin
            q_nxt.attn_n  = 1'b1;
            q_nxt.burst_n = 1'b1;
            q_nxt.st      = ST_DONE;
          end
        end else if (!q_r.retry) begin
          // ready on the limit edge itself is still in time
          if (q_r.wcnt == limit - 4'h1) begin
            q_nxt.stop_n  = 1'b0;
            q_nxt.retry   = 1'b1;
            q_nxt.burst_n = 1'b1;
          end else begin
            q_nxt.wcnt = q_r.wcnt + 4'h1;
          end
        end
      end

      ST_WRITE: begin
        q_nxt.ad_oe   = 1'b0;
        q_nxt.attn_n  = buf_empty && !buf_push;
        q_nxt.burst_n = q_r.retry || q_r.frame_s || q_r.bus_done;
        if (buf_push) begin
          q_nxt.lanes_n = q_r.cbe_s;
          q_nxt.trdy_n  = 1'b0;
          q_nxt.wcnt    = 4'h0;
          q_nxt.first   = 1'b0;
          if (q_r.taken != PHASES_FREE) begin
            q_nxt.taken = q_r.taken + 2'h1;
          end
          if (q_r.frame_s) begin
            q_nxt.bus_done = 1'b1;
          end
        end else if (!q_r.irdy_s && !q_r.bus_done && !q_r.retry) begin
          // the buffer is only full after two taken phases
          if (q_r.taken == PHASES_FREE && q_r.wcnt == NEXT_LIMIT - 4'h1) begin
            q_nxt.stop_n  = 1'b0;
            q_nxt.retry   = 1'b1;
            q_nxt.burst_n = 1'b1;
          end else begin
            q_nxt.wcnt = q_r.wcnt + 4'h1;
          end
        end
        if ((q_r.bus_done || q_r.retry) && buf_empty && !buf_push) begin
          q_nxt.attn_n  = 1'b1;
          q_nxt.burst_n = 1'b1;
          q_nxt.st      = ST_DONE;
        end
      end

      ST_DONE: begin
        q_nxt.attn_n  = 1'b1;
        q_nxt.burst_n = 1'b1;
        q_nxt.ad_oe   = 1'b0;
        q_nxt.st      = ST_IDLE;
      end

      default: begin
        q_nxt.st = ST_IDLE;
      end
    endcase

    // add-on read side: latched address first, then the data port
    q_nxt.dq_oe  = 1'b0;
    q_nxt.dq_out = ZERO_WORD;
    if (!latched_addr_read_n) begin
      q_nxt.dq_oe  = 1'b1;
      q_nxt.dq_out = mode_16 ? {ZERO_HALF, q_r.addr[15:0]} : q_r.addr;
    end else if (port_rd) begin
      q_nxt.dq_oe  = 1'b1;
      q_nxt.dq_out = buf_head;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_r         <= '0;
      q_r.st      <= ST_IDLE;
      q_r.frame_m <= 1'b1;
      q_r.frame_s <= 1'b1;
      q_r.frame_d <= 1'b1;
      q_r.irdy_m  <= 1'b1;
      q_r.irdy_s  <= 1'b1;
      q_r.lanes_n <= LANES_IDLE_N;
      q_r.attn_n  <= 1'b1;
      q_r.burst_n <= 1'b1;
      q_r.trdy_n  <= 1'b1;
      q_r.stop_n  <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign pci_ad_out           = q_r.ad_out;
  assign pci_ad_oe            = q_r.ad_oe;
  assign pci_trdy_n           = q_r.trdy_n;
  assign pci_stop_n           = q_r.stop_n;
  assign addon_dq_out         = q_r.dq_out;
  assign addon_dq_oe          = q_r.dq_oe;
  assign passthru_attention_n = q_r.attn_n;
  assign burst_flag_n         = q_r.burst_n;
  assign region_index         = q_r.region;
  assign xfer_direction       = q_r.dir;
  assign pending_byte_lanes_n = q_r.lanes_n;

  a_status_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !q_r.attn_n && !q_nxt.attn_n && q_r.st == q_nxt.st
      |=> $stable(region_index) && $stable(xfer_direction))
    else $error("status changed while attention held");

  a_read_dir: assert property (@(posedge core_clk) disable iff (sys_rst)
    q_r.st == ST_READ |-> !xfer_direction)
    else $error("direction high during read");

  a_trdy_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
    q_r.st == ST_READ && ready && !q_r.retry |=> !pci_trdy_n)
    else $error("target ready not one clock after add-on ready");

  a_trdy_cause: assert property (@(posedge core_clk) disable iff (sys_rst)
    !pci_trdy_n |-> $past(ready) || $past(buf_push))
    else $error("target ready without cause");

  a_attn_wait: assert property (@(posedge core_clk) disable iff (sys_rst)
    q_r.st == ST_READ && q_r.irdy_s && !q_r.retry && !ready
      |=> passthru_attention_n)
    else $error("attention held during initiator wait");

  a_first_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
    q_r.st == ST_IDLE && q_nxt.st == ST_READ ##1
      (addon_ready_n && q_r.st == ST_READ) [*8] ##1
      (addon_ready_n && q_r.st == ST_READ) [*8]
      |-> q_r.retry)
    else $error("no stop after first phase limit");

  a_stop_burst: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(pci_stop_n) |-> burst_flag_n && q_r.retry)
    else $error("burst flag held after stop");

  a_done_gap: assert property (@(posedge core_clk) disable iff (sys_rst)
    q_r.st == ST_DONE |-> passthru_attention_n && burst_flag_n
      ##1 q_r.st == ST_IDLE)
    else $error("completion gap wrong");

  a_write_first: assert property (@(posedge core_clk) disable iff (sys_rst)
    q_r.st == ST_WRITE && q_r.taken != PHASES_FREE |-> q_r.retry == 1'b0)
    else $error("stop before two write phases");

  a_write_empty: assert property (@(posedge core_clk) disable iff (sys_rst)
    q_r.st == ST_WRITE && q_nxt.st == ST_DONE |-> buf_empty)
    else $error("write access ended with buffered data");

  a_addr16: assert property (@(posedge core_clk) disable iff (sys_rst)
    !latched_addr_read_n && mode_16
      |=> addon_dq_oe && addon_dq_out[31:16] == ZERO_HALF)
    else $error("upper address bits driven in 16-bit mode");
endmodule

/* tb/ptb_pci_init.sv */
`timescale 1ns/1ps
module ptb_pci_init (
  input  wire logic        core_clk,
  input  wire logic        pci_trdy_n,
  input  wire logic        pci_stop_n,
  output logic             pci_frame_n,
  output logic             pci_irdy_n,
  output logic [31:0]      ad,
  output logic [3:0]       pci_cbe_n
);
  // frame and irdy have pull-ups, so idle is high
  initial begin
    pci_frame_n = 1'b1;
    pci_irdy_n  = 1'b1;
    ad          = 32'h0;
    pci_cbe_n   = 4'hf;
  end
  // write data is the address plus the phase number
  task automatic run(input logic w, input int n, input int wt,
                     input logic [31:0] a);
    int i;
    int k;
    @(posedge core_clk);
    pci_frame_n <= 1'b0;
    ad          <= a;
    pci_cbe_n   <= {3'h3, w};
    @(posedge core_clk);
    for (i = 0; i < n; i++) begin
      pci_irdy_n  <= 1'b0;
      pci_frame_n <= (i == n - 1);
      pci_cbe_n   <= 4'h0;
      ad          <= w ? a + i : ~ad;
      k = 0;
      do begin
        @(posedge core_clk);
        k++;
      end while (pci_trdy_n !== 1'b0 && pci_stop_n !== 1'b0 && k < 60);
      // a retry ends the access at once, as a real initiator would
      if (pci_stop_n === 1'b0) break;
      if (i == wt) begin
        pci_irdy_n <= 1'b1;
        @(posedge core_clk);
      end
    end
    pci_frame_n <= 1'b1;
    pci_irdy_n  <= 1'b1;
    ad          <= ~ad;
    pci_cbe_n   <= 4'hf;
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import ptb_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        frame_n, irdy_n, trdy_n, stop_n, ad_oe, dq_oe;
  logic        attn_n, burst_n, dir, mode_16 = 1'b0, laddr_n = 1'b1;
  logic        sel_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1, rdy_n = 1'b1;
  logic        wr_mode = 1'b0, rd_due = 1'b0, stop_seen = 1'b0;
  logic [1:0]  region;
  logic [3:0]  cbe_n, lanes;
  logic [6:2]  adr = 5'h00;
  logic [15:0] lf = 16'h81fb;
  logic [31:0] init_ad, ad_out, dq_out, dq_tb = 32'h0;
  logic [31:0] rq[$], wq[$];
  int          mismatches = 0, samples_checked = 0, cyc = 0, trdy_cnt = 0;

  initial forever #25 core_clk = ~core_clk;

  ptb_pci_init u_ptb_pci_init (.core_clk(core_clk), .pci_trdy_n(trdy_n),
    .pci_stop_n(stop_n), .pci_frame_n(frame_n), .pci_irdy_n(irdy_n),
    .ad(init_ad), .pci_cbe_n(cbe_n));

  ptb_target_port u_ptb_target_port (.core_clk(core_clk), .sys_rst(sys_rst),
    .pci_frame_n(frame_n), .pci_irdy_n(irdy_n),
    .pci_ad_in(ad_oe ? ad_out : init_ad), .pci_cbe_n(cbe_n),
    .pci_ad_out(ad_out), .pci_ad_oe(ad_oe), .pci_trdy_n(trdy_n),
    .pci_stop_n(stop_n), .mode_16(mode_16), .addon_sel_n(sel_n),
    .addon_adr(adr), .addon_wr_n(wr_n), .addon_rd_n(rd_n),
    .addon_ready_n(rdy_n), .latched_addr_read_n(laddr_n),
    .addon_dq_in(dq_oe ? dq_out : dq_tb), .addon_dq_out(dq_out),
    .addon_dq_oe(dq_oe), .passthru_attention_n(attn_n),
    .burst_flag_n(burst_n), .region_index(region), .xfer_direction(dir),
    .pending_byte_lanes_n(lanes));

  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wait_attn(input logic v, input int lim);
    int k;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (attn_n !== v && k < lim);
    chk("attention", attn_n, v);
  endtask

  // ready is held until an edge sees attention low, so no word is lost
  task automatic put(input logic [31:0] d, input logic r, hw);
    int k;
    @(posedge core_clk);
    wr_n  <= 1'b0;
    rdy_n <= ~r;
    dq_tb <= d;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (attn_n !== 1'b0 && k < 20);
    wr_n  <= ~hw;
    rdy_n <= 1'b1;
    dq_tb <= ~d;
  endtask

  task automatic rd_burst(input int n, wt, sp, sl, input logic m, hw);
    logic [31:0] a;
    logic [31:0] d;
    int          i;
    d = {rnd(), rnd()};
    a = {20'h80000, d[11:2], 2'h0};
    mode_16 <= m;
    stop_seen = 1'b0;
    fork
      u_ptb_pci_init.run(1'b0, n, wt, a);
      begin
        wait_attn(1'b0, 5);
        chk("region", region, a[11:10]);
        chk("dir", dir, 1'b0);
        @(posedge core_clk);
        laddr_n <= 1'b0;
        @(posedge core_clk);
        laddr_n <= 1'b1;
        @(negedge core_clk);
        chk("addr", dq_out, m ? {ZERO_HALF, a[15:0]} : a);
        chk("lanes", lanes, 4'h0);
        for (i = 0; i < n; i++) begin
          if (i == sp) begin
            repeat (sl) @(posedge core_clk);
            @(negedge core_clk);
            chk("stop", stop_seen, 1'b1);
            chk("burst", burst_n, 1'b1);
            chk("region", region, a[11:10]);
          end else if (i == 1) chk("burst", burst_n, 1'b0);
          d = {rnd(), rnd()};
          if (i != sp) rq.push_back(d);
          put(d, 1'b1, hw);
          if (i == sp) begin
            @(negedge core_clk);
            chk("attention", attn_n, 1'b1);
            break;
          end
          // target ready stands for one clock only
          @(negedge core_clk);
          chk("trdy", trdy_n, 1'b0);
          if (i == n - 1) begin
            chk("attention", attn_n, 1'b1);
            chk("burst", burst_n, 1'b1);
            put(~d, 1'b0, 1'b0);
          end
          if (i == wt) wait_attn(1'b1, 6);
          else repeat (4) @(posedge core_clk);
        end
      end
    join
    @(posedge core_clk);
    wr_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask

  task automatic wr_burst();
    logic [31:0] a;
    logic [31:0] d;
    int          j;
    d = {rnd(), rnd()};
    a = {20'h80000, d[11:2], 2'h0};
    wq.push_back(a);
    wq.push_back(a + 1);
    wr_mode = 1'b1;
    stop_seen = 1'b0;
    trdy_cnt = 0;
    fork
      u_ptb_pci_init.run(1'b1, 4, 9, a);
      begin
        repeat (14) @(negedge core_clk);
        chk("trdy count", trdy_cnt, 2);
        chk("dir", dir, 1'b1);
        chk("attention", attn_n, 1'b0);
        repeat (12) @(posedge core_clk);
        chk("stop", stop_seen, 1'b1);
        for (j = 0; j < 2; j++) begin
          @(posedge core_clk);
          rd_n <= 1'b0;
          @(posedge core_clk);
          rd_n   <= 1'b1;
          rd_due = 1'b1;
          rdy_n  <= 1'b0;
          @(posedge core_clk);
          rdy_n <= 1'b1;
          // the last pop empties the buffer; attention drops a clock later
          if (j == 1) @(posedge core_clk);
          @(negedge core_clk);
          chk("attention", attn_n, j[0]);
        end
      end
    join
    wr_mode = 1'b0;
  endtask

  // results are compared here, against notes queued by the drivers
  always @(negedge core_clk) begin
    if (stop_n === 1'b0) stop_seen = 1'b1;
    if (trdy_n === 1'b0) trdy_cnt++;
    if (trdy_n === 1'b0 && !wr_mode) begin
      if (rq.size() == 0) chk("extra trdy", 1'b1, 1'b0);
      else chk("pci data", ad_out, rq.pop_front());
    end
    if (rd_due) begin
      rd_due = 1'b0;
      chk("port data", dq_out, wq.pop_front());
    end
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    sel_n   <= 1'b0;
    adr     <= PT_DATA_OFS[6:2];
    @(negedge core_clk);
    chk("attention", attn_n, 1'b1);
    chk("burst", burst_n, 1'b1);
    chk("lanes", lanes, LANES_IDLE_N);
    rd_burst(4, 1, 9, 0, 1'b0, 1'b0);
    rd_burst(3, 9, 0, 20, 1'b1, 1'b0);
    rd_burst(4, 9, 1, 10, 1'b0, 1'b1);
    wr_burst();
    repeat (10) @(posedge core_clk);
    finish_test();
  end
endmodule
